// ===== fvec_pkg.sv
// Constants shared by the flash verify and emulation command sequencer
package fvec_pkg;
  // ==========================================================================
  // Register offsets on the plain register port
  localparam logic [2:0] REG_STAT = 3'h0; // Status and launch
  localparam logic [2:0] REG_INDEX = 3'h1; // Parameter index
  localparam logic [2:0] REG_PARAM = 3'h2; // Parameter word at the index
  localparam logic [2:0] REG_ERRSTAT = 3'h3; // Emulation error status
  localparam logic [2:0] REG_EEE = 3'h4; // Emulation state
  // ==========================================================================
  // Field positions
  localparam int STAT_COMMAND_COMPLETE_FLAG_BIT = 7;
  localparam int STAT_ACCESS_ERROR_FLAG_BIT = 5;
  localparam int STAT_PROTECT_VIOLATION_FLAG_BIT = 4;
  localparam int STAT_MG1_BIT = 1;
  localparam int STAT_MG0_BIT = 0;
  localparam int ERR_EPVIOL_BIT = 0;
  localparam int EEE_HALTED_BIT = 0;
  // ==========================================================================
  // Command codes, taken from the upper byte of parameter word 0
  localparam logic [7:0] CMD_VERIFY_BLOCK = 8'h02;
  localparam logic [7:0] CMD_VERIFY_SECTION = 8'h03;
  localparam logic [7:0] CMD_EEE_DISABLE = 8'h14;
  localparam logic [7:0] CMD_EEE_QUERY = 8'h15;
  // ==========================================================================
  // Index values expected at launch, alignment and limits
  localparam logic [2:0] IDX_NO_ARGS = 3'h0;
  localparam logic [2:0] IDX_SECTION = 3'h2;
  localparam logic [2:0] PHRASE_LSB = 3'h0;
  localparam logic [16:0] SEG_PHRASES = 17'h04000; // 128 Kbyte in 8-byte phrases
  // ==========================================================================
  // Unpartitioned query values and parameter reset value
  localparam logic [15:0] QRY_SIZE_UNPART = 16'hFFFF;
  localparam logic [7:0] QRY_CNT_UNPART = 8'h00;
  localparam logic [15:0] PARAM_RESET = 16'h0000;
endpackage

// ===== fvec_seq.sv
// Flash erase verify and emulation control command sequencer
// ============================================================================
// Operation
// - block verify and disable need index zero
// - block verify flags bad block select
// - fatal verify reads set both status bits, other read errors only the error bit
// - section complete only after check finishes
// - section verify needs index two
// - section verify refused in disallowed mode
// - section verify flags invalid global address
// - section start must be phrase aligned
// - section must not cross 128K boundary
// - disable halts emulation, keeps tags, completes
// - disable refused before any partitioning
// - query returns partition settings and status
// - query fills indices one through four
// - unpartitioned query returns all-ones sizes and erase count, zero sector counts
module fvec_seq #(
  parameter int IDX_DEPTH = 8, // Parameter array entries
  parameter logic [6:0] BLK_LO = 7'h78, // Lowest valid block select
  parameter logic [6:0] BLK_HI = 7'h7F, // Highest valid block select
  parameter logic [15:0] BLOCK_PHRASES = 16'h2000 // Phrases in one block verify
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [2:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  input wire logic section_cmd_enable,
  input wire logic partition_done,
  input wire logic [15:0] data_flash_partition_size,
  input wire logic [15:0] buffer_ram_partition_size,
  input wire logic [15:0] sector_erase_count,
  input wire logic [7:0] dead_sector_count,
  input wire logic [7:0] ready_sector_count,
  input wire logic eee_idle,
  output logic eee_halt,
  output logic fl_rd_en,
  output logic [22:0] fl_rd_addr,
  input wire logic fl_rd_ack,
  input wire logic fl_blank,
  input wire logic fl_err,
  input wire logic fl_fatal
);
  // ==========================================================================
  // Types and state
  typedef enum logic [2:0] {FVEC_IDLE, FVEC_VERIFY, FVEC_HALT, FVEC_QUERY} fvec_state_t;
  fvec_state_t state; // Sequencer state
  fvec_state_t next_state; // Next sequencer state
  logic [15:0] param [IDX_DEPTH]; // Command parameter array
  logic [2:0] parameter_index; // Array index
  logic command_complete_flag; // High while idle
  logic access_error_flag; // Sticky, write one to clear
  logic protect_violation_flag; // Sticky, never set here
  logic verify_error_status; // Any verify error
  logic verify_fatal_status; // Non-correctable verify error
  logic emulation_protect_violation_flag; // Sticky, never set here
  logic [15:0] remain; // Phrases left to verify
  logic [15:0] next_remain;
  logic [22:0] next_fl_rd_addr;
  // ==========================================================================
  // Register decode
  wire wr_stat = wr && (addr == fvec_pkg::REG_STAT);
  wire wr_index = wr && (addr == fvec_pkg::REG_INDEX);
  wire wr_param = wr && (addr == fvec_pkg::REG_PARAM);
  wire wr_err = wr && (addr == fvec_pkg::REG_ERRSTAT);
  // Launch ignored while an error flag from a previous command still stands
  wire launch = wr_stat && wdata[fvec_pkg::STAT_COMMAND_COMPLETE_FLAG_BIT] && command_complete_flag
    && !access_error_flag && !protect_violation_flag;
  // ==========================================================================
  // Parameter checks at launch, from the array contents, the index and the mode inputs
  wire [7:0] cmd = param[0][15:8];
  wire [6:0] blk = param[0][6:0];
  wire [22:0] start_addr = {blk, param[1]};
  wire [15:0] count = param[2];
  wire is_block = (cmd == fvec_pkg::CMD_VERIFY_BLOCK);
  wire is_section = (cmd == fvec_pkg::CMD_VERIFY_SECTION);
  wire is_disable = (cmd == fvec_pkg::CMD_EEE_DISABLE);
  wire is_query = (cmd == fvec_pkg::CMD_EEE_QUERY);
  wire blk_ok = (blk >= BLK_LO) && (blk <= BLK_HI);
  // Phrase offset inside the 128K segment plus count must stay in the segment
  wire [16:0] seg_end = {3'h0, start_addr[16:3]} + {1'b0, count};
  wire idx0_bad = (parameter_index != fvec_pkg::IDX_NO_ARGS);
  wire err_block = idx0_bad || !blk_ok;
  wire err_section = (parameter_index != fvec_pkg::IDX_SECTION)
    || !section_cmd_enable
    || !blk_ok
    || (start_addr[2:0] != fvec_pkg::PHRASE_LSB)
    || (seg_end > fvec_pkg::SEG_PHRASES);
  wire err_disable = idx0_bad || !partition_done;
  // Unknown codes are refused rather than silently completed
  wire launch_err = is_block ? err_block : is_section ? err_section :
    is_disable ? err_disable : !is_query;
  wire launch_ok = launch && !launch_err;
  // ==========================================================================
  // Query results: all-ones sizes and erase count, zero sector counts before partitioning
  wire [15:0] q_df = partition_done ? data_flash_partition_size : fvec_pkg::QRY_SIZE_UNPART;
  wire [15:0] q_er = partition_done ? buffer_ram_partition_size : fvec_pkg::QRY_SIZE_UNPART;
  wire [15:0] q_ec = partition_done ? sector_erase_count : fvec_pkg::QRY_SIZE_UNPART;
  wire [7:0] q_dead = partition_done ? dead_sector_count : fvec_pkg::QRY_CNT_UNPART;
  wire [7:0] q_ready = partition_done ? ready_sector_count : fvec_pkg::QRY_CNT_UNPART;
  wire [15:0] query_word [IDX_DEPTH];
  wire query_slot = (state == FVEC_QUERY); // Query or empty section finishing
  wire query_load = query_slot && is_query; // Only a real query may overwrite the array
  wire verify_last = (state == FVEC_VERIFY) && fl_rd_ack && (remain == 16'h0001);
  wire done = verify_last || query_slot || ((state == FVEC_HALT) && eee_idle);
  // ==========================================================================
  // Parameter array, one entry per generate step
  for (genvar i = 0; i < IDX_DEPTH; i++) begin : g_param
    // Query words land at indices 1 to 4, the rest keep their value
    assign query_word[i] = (i == 1) ? q_df : (i == 2) ? q_er : (i == 3) ? q_ec :
      (i == 4) ? {q_dead, q_ready} : param[i];
    always_ff @(posedge clk) begin
      if (srst) begin
        param[i] <= fvec_pkg::PARAM_RESET;
      end else if (query_load) begin
        param[i] <= query_word[i];
      end else if (wr_param && (parameter_index == 3'(i)) && command_complete_flag) begin
        param[i] <= wdata;
      end
    end
  end
  // ==========================================================================
  // Next state and verify walk
  always_comb begin
    next_state = state;
    next_remain = remain;
    next_fl_rd_addr = fl_rd_addr;
    case (state)
      FVEC_IDLE: begin
        if (launch_ok && (is_block || is_section)) begin
          // Whole block starts at offset zero, section at its first phrase
          next_state = FVEC_VERIFY;
          next_remain = is_block ? BLOCK_PHRASES : count;
          next_fl_rd_addr = is_block ? {blk, 16'h0000} : start_addr;
          // An empty section has nothing to read and finishes next cycle
          if (!is_block && (count == 16'h0000)) begin
            next_state = FVEC_QUERY;
            next_fl_rd_addr = start_addr;
          end
        end else if (launch_ok && is_disable) begin
          next_state = FVEC_HALT;
        end else if (launch_ok) begin
          next_state = FVEC_QUERY;
        end
      end
      FVEC_VERIFY: begin
        if (fl_rd_ack) begin
          next_remain = remain - 16'h0001;
          next_fl_rd_addr = fl_rd_addr + 23'h000008;
          if (remain == 16'h0001) begin
            next_state = FVEC_IDLE;
          end
        end
      end
      FVEC_HALT: begin
        // Wait for the emulation engine to reach a safe stopping point
        if (eee_idle) begin
          next_state = FVEC_IDLE;
        end
      end
      FVEC_QUERY: next_state = FVEC_IDLE;
      default: next_state = FVEC_IDLE;
    endcase
  end
  // Empty section reuses the one-cycle query slot only for completion timing,
  // so the array load is gated on the query code and the section keeps its words
  // ==========================================================================
  // Sequencer registers
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= FVEC_IDLE;
      remain <= 16'h0000;
      fl_rd_addr <= 23'h000000;
    end else begin
      state <= next_state;
      remain <= next_remain;
      fl_rd_addr <= next_fl_rd_addr;
    end
  end
  // ==========================================================================
  // Index register, held while a command runs
  always_ff @(posedge clk) begin
    if (srst) begin
      parameter_index <= 3'h0;
    end else if (wr_index && command_complete_flag) begin
      parameter_index <= wdata[2:0];
    end
  end
  // ==========================================================================
  // Status flags
  always_ff @(posedge clk) begin
    if (srst) begin
      command_complete_flag <= 1'b1;
      access_error_flag <= 1'b0;
      protect_violation_flag <= 1'b0;
      verify_error_status <= 1'b0;
      verify_fatal_status <= 1'b0;
    end else begin
      // Cleared by an accepted launch, set once the command has finished
      if (launch_ok) begin
        command_complete_flag <= 1'b0;
      end else if (done) begin
        command_complete_flag <= 1'b1;
      end
      // Set wins over a write-one clear in the same cycle
      if (launch && launch_err) begin
        access_error_flag <= 1'b1;
      end else if (wr_stat && wdata[fvec_pkg::STAT_ACCESS_ERROR_FLAG_BIT]) begin
        access_error_flag <= 1'b0;
      end
      // No command here raises a protection error
      if (wr_stat && wdata[fvec_pkg::STAT_PROTECT_VIOLATION_FLAG_BIT]) begin
        protect_violation_flag <= 1'b0;
      end
      // Verify status restarts with each launch and accumulates over the read
      if (launch) begin
        verify_error_status <= 1'b0;
        verify_fatal_status <= 1'b0;
      end else if ((state == FVEC_VERIFY) && fl_rd_ack) begin
        verify_error_status <= verify_error_status | !fl_blank | fl_err | fl_fatal;
        verify_fatal_status <= verify_fatal_status | fl_fatal;
      end
    end
  end
  // ==========================================================================
  // Emulation halt state and its error flag
  always_ff @(posedge clk) begin
    if (srst) begin
      eee_halt <= 1'b0;
      emulation_protect_violation_flag <= 1'b0;
    end else begin
      // Halt request stays up once given; tag storage is never touched here
      if (launch_ok && is_disable) begin
        eee_halt <= 1'b1;
      end
      if (wr_err && wdata[fvec_pkg::ERR_EPVIOL_BIT]) begin
        emulation_protect_violation_flag <= 1'b0;
      end
    end
  end
  // ==========================================================================
  // Flash read request and read data
  assign fl_rd_en = (state == FVEC_VERIFY);
  wire [15:0] stat_word = {8'h00, command_complete_flag, 1'b0, access_error_flag,
    protect_violation_flag, 2'b00, verify_error_status, verify_fatal_status};
  wire [15:0] rd_mux = (addr == fvec_pkg::REG_STAT) ? stat_word :
    (addr == fvec_pkg::REG_INDEX) ? {13'h0000, parameter_index} :
    (addr == fvec_pkg::REG_PARAM) ? param[parameter_index] :
    (addr == fvec_pkg::REG_ERRSTAT) ? {15'h0000, emulation_protect_violation_flag} :
    (addr == fvec_pkg::REG_EEE) ? {15'h0000, eee_halt} : 16'h0000;
  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata <= 16'h0000;
    end else begin
      rdata <= rd ? rd_mux : 16'h0000;
    end
  end
  // ==========================================================================
  // Checks
  bad_index_a: assert property (@(posedge clk) disable iff (srst)
    (launch && (is_block || is_disable) && idx0_bad) |=> access_error_flag && command_complete_flag)
    else $error("bad index did not raise access error");
  bad_block_a: assert property (@(posedge clk) disable iff (srst)
    (launch && is_block && !blk_ok) |=> access_error_flag && (state == FVEC_IDLE))
    else $error("bad block select accepted");
  verify_fatal_a: assert property (@(posedge clk) disable iff (srst)
    ((state == FVEC_VERIFY) && fl_rd_ack && fl_fatal) |=> verify_fatal_status && verify_error_status)
    else $error("fatal read not recorded");
  section_done_a: assert property (@(posedge clk) disable iff (srst)
    (state == FVEC_VERIFY) |-> !command_complete_flag)
    else $error("complete flag set during verify");
  section_index_a: assert property (@(posedge clk) disable iff (srst)
    (launch && is_section && (parameter_index != fvec_pkg::IDX_SECTION)) |=> access_error_flag)
    else $error("section launched with wrong index");
  section_mode_a: assert property (@(posedge clk) disable iff (srst)
    (launch && is_section && !section_cmd_enable) |=> (state == FVEC_IDLE) && access_error_flag)
    else $error("section ran in disallowed mode");
  section_align_a: assert property (@(posedge clk) disable iff (srst)
    (launch && is_section && (start_addr[2:0] != 3'h0)) |=> access_error_flag)
    else $error("misaligned section accepted");
  section_cross_a: assert property (@(posedge clk) disable iff (srst)
    (launch && is_section && (seg_end > 17'h04000)) |=> access_error_flag)
    else $error("segment crossing accepted");
  disable_part_a: assert property (@(posedge clk) disable iff (srst)
    (launch && is_disable && !partition_done) |=> !eee_halt || $past(eee_halt))
    else $error("disable ran before partitioning");
  query_unpart_a: assert property (@(posedge clk) disable iff (srst)
    (query_load && !partition_done && is_query) |=> (param[1] == 16'hFFFF) && (param[4] == 16'h0000))
    else $error("unpartitioned query values wrong");
  protect_hold_a: assert property (@(posedge clk) disable iff (srst)
    !$past(protect_violation_flag) |-> !protect_violation_flag)
    else $error("protection flag set by a command");
  empty_keep_a: assert property (@(posedge clk) disable iff (srst)
    (query_slot && !is_query) |=> (param[1] == $past(param[1])))
    else $error("empty section overwrote the array");
endmodule // fvec_seq

// ===== flash_verify_eee_cmd_sequencer_tb.sv
// Self-checking bench for the flash verify and emulation command sequencer
module flash_verify_eee_cmd_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Port signals and bench state
  logic clk, srst, wr, rd, section_cmd_enable, partition_done, eee_idle;
  logic [2:0] addr;
  logic [15:0] wdata, rdata;
  logic eee_halt, fl_rd_en, fl_rd_ack, fl_blank, fl_err, fl_fatal;
  logic [22:0] fl_rd_addr;
  logic [15:0] df_size = 16'h1234; // Partition inputs seen by a query
  logic [15:0] er_size = 16'h0456;
  logic [15:0] ec_cnt = 16'h0789;
  logic [7:0] dead_cnt = 8'h0A;
  logic [7:0] ready_cnt = 8'h0B;
  logic [22:0] exp_addr = 23'h000000; // Next phrase the sequencer should ask for
  logic [22:0] bad_addr = 23'h000000; // Phrase that answers with a fault
  logic [22:0] n_acks = 23'h000000; // Phrases answered in this command
  int err_mode = 0; // 0 clean, 1 error, 2 fatal, 3 not blank
  int num_errors = 0;
  int checks_done = 0;

  fvec_seq #(.BLOCK_PHRASES(16'h0004)) fvec_seq_inst (
    .clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .section_cmd_enable(section_cmd_enable), .partition_done(partition_done),
    .data_flash_partition_size(df_size), .buffer_ram_partition_size(er_size),
    .sector_erase_count(ec_cnt), .dead_sector_count(dead_cnt), .ready_sector_count(ready_cnt),
    .eee_idle(eee_idle), .eee_halt(eee_halt), .fl_rd_en(fl_rd_en), .fl_rd_addr(fl_rd_addr),
    .fl_rd_ack(fl_rd_ack), .fl_blank(fl_blank), .fl_err(fl_err), .fl_fatal(fl_fatal));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ==========================================================================
  // Flash array stand-in: acks every other cycle, status lines churn when idle
  always @(posedge clk) begin
    if (fl_rd_en === 1'b1 && fl_rd_ack === 1'b0) begin
      check("read address", fl_rd_addr, exp_addr);
      fl_rd_ack <= 1'b1;
      fl_blank <= !(exp_addr == bad_addr && err_mode == 3);
      fl_err <= (exp_addr == bad_addr && err_mode == 1);
      fl_fatal <= (exp_addr == bad_addr && err_mode == 2);
      exp_addr <= exp_addr + 23'h000008;
      n_acks <= n_acks + 23'h000001;
    end else begin
      // Invalid outside an ack, so never leave a friendly value behind
      fl_rd_ack <= 1'b0;
      fl_blank <= ~fl_blank;
      fl_err <= ~fl_err;
      fl_fatal <= ~fl_fatal;
    end
  end

  // ==========================================================================
  // Bus and checking tasks
  task automatic check(input string name, input logic [22:0] seen, input logic [22:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("Checks %0d, errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [2:0] a, output logic [15:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic expect_reg(input logic [2:0] a, input logic [15:0] e, input string name);
    logic [15:0] v;
    rd_reg(a, v);
    check(name, {7'h00, v}, {7'h00, e});
  endtask

  // Load words 0..2, leave the index at idx, then launch
  task automatic run(input logic [15:0] w0, w1, w2, input logic [2:0] idx);
    for (int i = 0; i < 3; i++) begin
      wr_reg(fvec_pkg::REG_INDEX, 16'(i));
      wr_reg(fvec_pkg::REG_PARAM, (i == 0) ? w0 : (i == 1) ? w1 : w2);
    end
    wr_reg(fvec_pkg::REG_INDEX, {13'h0000, idx});
    n_acks = 23'h000000;
    wr_reg(fvec_pkg::REG_STAT, 16'h0080);
  endtask

  // Bounded poll of the complete flag; running out ends the run
  task automatic wait_done(input int max);
    logic [15:0] v;
    v = 16'h0000;
    for (int i = 0; i < max && v[7] !== 1'b1; i++) rd_reg(fvec_pkg::REG_STAT, v);
    if (v[7] !== 1'b1) begin
      num_errors++;
      $display("ERROR complete flag expected 1 seen %b", v[7]);
      summarize();
    end
  endtask

  task automatic err_case(input logic [15:0] w0, w1, w2, input logic [2:0] idx,
                          input logic sec_en, part);
    section_cmd_enable <= sec_en;
    partition_done <= part;
    run(w0, w1, w2, idx);
    expect_reg(fvec_pkg::REG_STAT, 16'h00A0, "status after refused launch");
    wr_reg(fvec_pkg::REG_STAT, 16'h0080);
    expect_reg(fvec_pkg::REG_STAT, 16'h00A0, "launch while error pending");
    check("phrase reads", n_acks, 23'h000000);
    check("halt", {22'h000000, eee_halt}, 23'h000000);
    wr_reg(fvec_pkg::REG_STAT, 16'h0020);
    expect_reg(fvec_pkg::REG_STAT, 16'h0080, "status after clear");
  endtask

  task automatic op_verify(input logic [15:0] w0, w1, w2, input logic [2:0] idx,
                           input logic [22:0] start, bad, input int mode, nphr,
                           input logic [15:0] stat, input logic busy_chk);
    exp_addr = start;
    bad_addr = bad;
    err_mode = mode;
    run(w0, w1, w2, idx);
    if (busy_chk) expect_reg(fvec_pkg::REG_STAT, 16'h0000, "status while verifying");
    wait_done(60);
    check("phrase reads", n_acks, 23'(nphr));
    expect_reg(fvec_pkg::REG_STAT, stat, "verify status");
  endtask

  task automatic query_check(input logic [15:0] e [4]);
    run(16'h1500, 16'h5555, 16'hAAAA, 3'h0);
    wait_done(10);
    for (int i = 1; i <= 4; i++) begin
      wr_reg(fvec_pkg::REG_INDEX, 16'(i));
      expect_reg(fvec_pkg::REG_PARAM, e[i-1], "query word");
    end
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    {srst, wr, rd, section_cmd_enable, partition_done, eee_idle} = 6'b100100;
    addr = 3'h0;
    wdata = 16'h0000;
    {fl_rd_ack, fl_blank, fl_err, fl_fatal} = 4'b0000;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    expect_reg(fvec_pkg::REG_STAT, 16'h0080, "status after reset");
    expect_reg(3'h7, 16'h0000, "unmapped read");
    expect_reg(fvec_pkg::REG_EEE, 16'h0000, "halt after reset");
    query_check('{16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h0000});
    err_case(16'h0278, 16'h0000, 16'h0000, 3'h1, 1'b1, 1'b1);
    err_case(16'h0210, 16'h0000, 16'h0000, 3'h0, 1'b1, 1'b1);
    err_case(16'h0378, 16'h0000, 16'h0001, 3'h1, 1'b1, 1'b1);
    err_case(16'h0378, 16'h0000, 16'h0001, 3'h2, 1'b0, 1'b1);
    err_case(16'h0310, 16'h0000, 16'h0001, 3'h2, 1'b1, 1'b1);
    err_case(16'h0378, 16'h0004, 16'h0001, 3'h2, 1'b1, 1'b1);
    err_case(16'h0379, 16'hFFF8, 16'h0002, 3'h2, 1'b1, 1'b1);
    err_case(16'h1400, 16'h0000, 16'h0000, 3'h1, 1'b1, 1'b1);
    err_case(16'h1400, 16'h0000, 16'h0000, 3'h0, 1'b1, 1'b0);
    partition_done <= 1'b1;
    // Modes 2 and 3 follow a faulting one, so stale status must be cleared
    for (int m = 0; m < 4; m++) begin
      op_verify(16'h0278, 16'h0000, 16'h0000, 3'h0, 23'h780000, 23'h780010, m, 4,
                (m == 0) ? 16'h0080 : (m == 2) ? 16'h0083 : 16'h0082, 1'b1);
    end
    op_verify(16'h0379, 16'hFFF8, 16'h0001, 3'h2, 23'h79FFF8, 23'h0, 0, 1, 16'h0080,
              1'b0);
    op_verify(16'h0378, 16'h0010, 16'h0003, 3'h2, 23'h780010, 23'h780020, 2, 3, 16'h0083,
              1'b0);
    op_verify(16'h0378, 16'h0000, 16'h0000, 3'h2, 23'h780000, 23'h0, 0, 0, 16'h0080,
              1'b0);
    wr_reg(fvec_pkg::REG_INDEX, 16'h0001);
    expect_reg(fvec_pkg::REG_PARAM, 16'h0000, "array after empty section");
    query_check('{16'h1234, 16'h0456, 16'h0789, 16'h0A0B});
    run(16'h1400, 16'h0000, 16'h0000, 3'h0);
    expect_reg(fvec_pkg::REG_STAT, 16'h0000, "complete while halting");
    expect_reg(fvec_pkg::REG_EEE, 16'h0001, "halt state");
    eee_idle <= 1'b1;
    wait_done(10);
    expect_reg(fvec_pkg::REG_STAT, 16'h0080, "status after disable");
    expect_reg(fvec_pkg::REG_ERRSTAT, 16'h0000, "emulation protect flag");
    summarize();
  end

  // Hang guard far beyond the expected run length
  initial begin
    #2000000;
    num_errors++;
    $display("ERROR run length expected finish seen timeout");
    summarize();
  end
endmodule // flash_verify_eee_cmd_sequencer_tb
